// file: src/ctsc_cfg.svh
// constants of the clock, timing and standby controller
// assumes one clock at the high-frequency rate; APB word per register
`ifndef CTSC_CFG_SVH
`define CTSC_CFG_SVH

// ====================
// stages and timing
`define CTSC_PRESCALE_STAGES 3
`define CTSC_DIVIDER_STAGES 21
`define CTSC_CLK_PERIOD_NS 4
`define CTSC_FC_PER_MCYCLE 4
`define CTSC_MAX_INSTR_CYCLES 15
`define CTSC_WARM_UNIT_LOG2 16
`define CTSC_WARM_TRIPLE 3

// ====================
// register indices; byte address is four times the index
`define CTSC_IDX_DCC 8'h34
`define CTSC_IDX_TBDC 8'h36
`define CTSC_IDX_SYS1 8'h38
`define CTSC_IDX_SYS2 8'h39
`define CTSC_IDX_STATUS 8'h3A

// ====================
// reset values
`define CTSC_RST_DCC 8'h00
`define CTSC_RST_TBDC 8'h00
`define CTSC_RST_SYS1 8'h00
`define CTSC_RST_SYS2 8'h80

// ====================
// field positions
`define CTSC_TB_DIVIDER_OUTPUT_ENABLE 7
`define CTSC_TB_DIVIDER_OUTPUT_CLOCK_SELECT_LO 5
`define CTSC_TB_ZERO 4
`define CTSC_TB_TIME_BASE_ENABLE 3
`define CTSC_S1_STOP 7
`define CTSC_S1_STOP_RELEASE_METHOD 6
`define CTSC_S1_WUT_LO 2
`define CTSC_S2_XEN 7
`define CTSC_S2_SYSCK 5
`define CTSC_S2_IDLE 4
`define CTSC_DCC_DV1CK 5

// ====================
// divider chain taps
`define CTSC_DVO_TAP0 12
`define CTSC_WDT_TAP 15
`define CTSC_TMR_TAP0 2
`define CTSC_TMR_TAP1 6
`define CTSC_TMR_TAP2 10

`endif

// file: src/ctsc_pkg.sv
// types of the clock, timing and standby controller
// assumes ctsc_cfg.svh is on the include path
package ctsc_pkg;
	typedef enum logic [3:0] {
		MODE_NORMAL = 4'b0001,
		MODE_IDLE = 4'b0010,
		MODE_STOP = 4'b0100,
		MODE_WARM = 4'b1000
	} ctsc_mode_e;
	typedef enum logic [3:0] {
		MST_S0 = 4'b0001,
		MST_S1 = 4'b0010,
		MST_S2 = 4'b0100,
		MST_S3 = 4'b1000
	} ctsc_mstate_e;
endpackage

// file: src/ctsc_timing_gen.sv
// prescaler plus divider chain and machine cycle counter
// assumes clear and run come from the standby controller, same clock
`include "ctsc_cfg.svh"
module ctsc_timing_gen #(
	parameter int CHAIN_W = `CTSC_PRESCALE_STAGES + `CTSC_DIVIDER_STAGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic chainClear,
	input wire logic cycleRun,
	input wire logic instrStart,
	input wire logic [3:0] instrLen,
	// chain
	output logic [CHAIN_W-1:0] chain,
	output logic [CHAIN_W-1:0] chainRise,
	// machine cycle
	output ctsc_pkg::ctsc_mstate_e machState,
	output logic instrBusy,
	output logic instrDone
);
	logic [CHAIN_W-1:0] prevChain;
	logic [3:0] cyclesLeft;

	// ====================
	// chain
	always_ff @(posedge clk) begin
		if (sys_rst || chainClear) begin
			chain <= '0;
			prevChain <= '0;
		end else begin
			chain <= chain + 1'b1;
			prevChain <= chain;
		end
	end
	assign chainRise = chain & ~prevChain;

	// ====================
	// machine cycle: one state per fast clock, so four per cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			machState <= ctsc_pkg::MST_S0;
		end else if (cycleRun) begin
			case (machState)
			ctsc_pkg::MST_S0: machState <= ctsc_pkg::MST_S1;
			ctsc_pkg::MST_S1: machState <= ctsc_pkg::MST_S2;
			ctsc_pkg::MST_S2: machState <= ctsc_pkg::MST_S3;
			default: machState <= ctsc_pkg::MST_S0;
			endcase
		end
	end

	// ====================
	// instruction length in whole machine cycles, zero taken as one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cyclesLeft <= 4'h0;
			instrDone <= 1'b0;
		end else begin
			instrDone <= 1'b0;
			if (!instrBusy && instrStart) begin
				cyclesLeft <= (instrLen == 4'h0) ? 4'h1 : instrLen;
			end else if (instrBusy && cycleRun &&
					machState == ctsc_pkg::MST_S3) begin
				cyclesLeft <= cyclesLeft - 4'h1;
				instrDone <= (cyclesLeft == 4'h1);
			end
		end
	end
	assign instrBusy = (cyclesLeft != 4'h0);

	property p_state_step;
		@(posedge clk) disable iff (sys_rst)
		(cycleRun && machState == ctsc_pkg::MST_S0) |=>
			machState == ctsc_pkg::MST_S1;
	endproperty
	a_state_step: assert property (p_state_step)
		else $error("machine state did not advance");

	property p_instr_len;
		@(posedge clk) disable iff (sys_rst)
		(!instrBusy && instrStart && instrLen == 4'h1 &&
			machState == ctsc_pkg::MST_S0 && cycleRun) ##1 cycleRun[*3]
			|=> instrDone;
	endproperty
	a_instr_len: assert property (p_instr_len)
		else $error("one-cycle instruction did not finish in 4 clocks");
endmodule

// file: src/ctsc_clock_ctrl.sv
// top of the clock, timing and standby controller with APB slave
// assumes APB on clk, a stop-release pin from outside the clock domain
`include "ctsc_cfg.svh"
module ctsc_clock_ctrl #(
	parameter int WARM_UNIT_LOG2 = `CTSC_WARM_UNIT_LOG2
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and core
	input wire logic stopPin,
	input wire logic irqRequest,
	input wire logic interruptMasterEnableFlag,
	input wire logic instrStart,
	input wire logic [3:0] instrLen,
	// clock gating
	output logic oscEnable,
	output logic cpuClkEn,
	output logic wdtClkEn,
	output logic periphClkEn,
	output logic xenResetReq,
	// machine cycle
	output ctsc_pkg::ctsc_mstate_e machState,
	output logic instrDone,
	// source clocks
	output logic dividerOutputPulse,
	output logic timeBaseTick,
	output logic watchdogTick,
	output logic [2:0] timerSrcTick,
	output logic warmupTick,
	// mode exits
	output logic idleResumeService,
	output logic resumeNext
);
	localparam int CHAIN_W = `CTSC_PRESCALE_STAGES + `CTSC_DIVIDER_STAGES;

	ctsc_pkg::ctsc_mode_e mode, next_mode;
	logic [7:0] timeBaseCtl, sysCtlFirst, sysCtlSecond, divClkCtl;
	logic [7:0] regIdx, rdByte;
	logic [CHAIN_W-1:0] chain, chainRise, warmLast;
	logic pinMeta, pinSync, pinPrev, wrEn, rdHit, stopWrite, idleWrite;
	logic stopRelease, warmDone, chainClear, instrBusy;

	// ====================
	// apb decode: zero wait states, error on unmapped index
	assign regIdx = paddr[9:2];
	assign wrEn = psel && penable && pwrite;
	assign pready = 1'b1;
	always_comb begin
		rdHit = 1'b1;
		rdByte = 8'h00;
		if (paddr[11:10] != 2'b00) begin
			rdHit = 1'b0;
		end else if (regIdx == `CTSC_IDX_TBDC) begin
			rdByte = timeBaseCtl;
		end else if (regIdx == `CTSC_IDX_SYS1) begin
			rdByte = {sysCtlFirst[7:2], 2'b00};
		end else if (regIdx == `CTSC_IDX_SYS2) begin
			rdByte = {sysCtlSecond[7:4], 4'h0};
		end else if (regIdx == `CTSC_IDX_DCC) begin
			rdByte = {2'b00, divClkCtl[5], 5'h00};
		end else if (regIdx == `CTSC_IDX_STATUS) begin
			rdByte = {machState, mode};
		end else begin
			rdHit = 1'b0;
		end
	end
	assign prdata = {24'h000000, rdByte};
	assign pslverr = psel && penable && !rdHit;

	assign stopWrite = wrEn && paddr[11:10] == 2'b00 &&
		regIdx == `CTSC_IDX_SYS1 && pwdata[`CTSC_S1_STOP];
	assign idleWrite = wrEn && paddr[11:10] == 2'b00 &&
		regIdx == `CTSC_IDX_SYS2 && pwdata[`CTSC_S2_IDLE];

	// ====================
	// registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timeBaseCtl <= `CTSC_RST_TBDC;
		end else if (wrEn && paddr[11:10] == 2'b00 &&
				regIdx == `CTSC_IDX_TBDC) begin
			timeBaseCtl <= pwdata[7:0] & 8'hEF;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			divClkCtl <= `CTSC_RST_DCC;
		end else if (wrEn && paddr[11:10] == 2'b00 &&
				regIdx == `CTSC_IDX_DCC) begin
			divClkCtl <= pwdata[7:0] & 8'h20;
		end
	end

	// stop bit cleared by hardware on release; writes accepted in every mode, release wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sysCtlFirst <= `CTSC_RST_SYS1;
		end else if (stopRelease) begin
			sysCtlFirst[`CTSC_S1_STOP] <= 1'b0;
		end else if (wrEn && paddr[11:10] == 2'b00 &&
				regIdx == `CTSC_IDX_SYS1) begin
			sysCtlFirst <= {pwdata[7:2], 2'b00};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sysCtlSecond <= `CTSC_RST_SYS2;
		end else if (mode == ctsc_pkg::MODE_IDLE && irqRequest) begin
			sysCtlSecond[`CTSC_S2_IDLE] <= 1'b0;
		end else if (wrEn && paddr[11:10] == 2'b00 &&
				regIdx == `CTSC_IDX_SYS2) begin
			// bit 6 is written as zero; sysck keeps the fast clock
			sysCtlSecond <= {pwdata[7], 1'b0, 1'b0, pwdata[4], 4'h0};
		end
	end

	// ====================
	// stop-release pin synchroniser
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			pinPrev <= 1'b0;
		end else begin
			pinMeta <= stopPin;
			pinSync <= pinMeta;
			pinPrev <= pinSync;
		end
	end

	assign stopRelease = (mode == ctsc_pkg::MODE_STOP) &&
		(sysCtlFirst[`CTSC_S1_STOP_RELEASE_METHOD] ? pinSync : (pinSync && !pinPrev));

	// ====================
	// warm-up length: three units or one, unit doubled by dv1ck
	function automatic logic [CHAIN_W-1:0] warmEnd(input logic [1:0] wut,
			input logic dv1ck);
		logic [CHAIN_W-1:0] units;
		units = (wut == 2'b00) ? CHAIN_W'(`CTSC_WARM_TRIPLE) : CHAIN_W'(1);
		return CHAIN_W'(units << (WARM_UNIT_LOG2 + int'(dv1ck))) -
			CHAIN_W'(1);
	endfunction
	assign warmLast = warmEnd(sysCtlFirst[`CTSC_S1_WUT_LO+1:`CTSC_S1_WUT_LO],
		divClkCtl[`CTSC_DCC_DV1CK]);
	assign warmDone = (mode == ctsc_pkg::MODE_WARM) &&
		(chain == warmLast);

	// ====================
	// standby mode sequencer
	always_comb begin
		next_mode = mode;
		case (mode)
		ctsc_pkg::MODE_NORMAL: begin
			if (stopWrite) begin
				next_mode = (pwdata[`CTSC_S1_STOP_RELEASE_METHOD] && pinSync) ?
					ctsc_pkg::MODE_WARM : ctsc_pkg::MODE_STOP;
			end else if (idleWrite) begin
				next_mode = ctsc_pkg::MODE_IDLE;
			end
		end
		ctsc_pkg::MODE_IDLE: begin
			if (irqRequest) begin
				next_mode = ctsc_pkg::MODE_NORMAL;
			end
		end
		ctsc_pkg::MODE_STOP: begin
			if (stopRelease) begin
				next_mode = ctsc_pkg::MODE_WARM;
			end
		end
		ctsc_pkg::MODE_WARM: begin
			if (warmDone) begin
				next_mode = ctsc_pkg::MODE_NORMAL;
			end
		end
		default: next_mode = ctsc_pkg::MODE_NORMAL;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode <= ctsc_pkg::MODE_NORMAL;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idleResumeService <= 1'b0;
			resumeNext <= 1'b0;
		end else begin
			idleResumeService <= mode == ctsc_pkg::MODE_IDLE && irqRequest &&
				interruptMasterEnableFlag;
			resumeNext <= warmDone || (mode == ctsc_pkg::MODE_IDLE &&
				irqRequest && !interruptMasterEnableFlag);
		end
	end

	// chain held at zero through stop, so entry and exit both clear it
	assign chainClear = (mode == ctsc_pkg::MODE_STOP) || stopWrite;

	// ====================
	// clock gating
	assign oscEnable = (mode != ctsc_pkg::MODE_STOP) &&
		sysCtlSecond[`CTSC_S2_XEN];
	assign cpuClkEn = (mode == ctsc_pkg::MODE_NORMAL);
	assign wdtClkEn = (mode == ctsc_pkg::MODE_NORMAL);
	assign periphClkEn = (mode == ctsc_pkg::MODE_NORMAL) ||
		(mode == ctsc_pkg::MODE_IDLE);
	assign xenResetReq = !sysCtlSecond[`CTSC_S2_XEN];

	ctsc_timing_gen #(.CHAIN_W(CHAIN_W)) timing (
		.clk(clk),
		.sys_rst(sys_rst),
		.chainClear(chainClear),
		.cycleRun(cpuClkEn),
		.instrStart(instrStart),
		.instrLen(instrLen),
		.chain(chain),
		.chainRise(chainRise),
		.machState(machState),
		.instrBusy(instrBusy),
		.instrDone(instrDone)
	);

	// ====================
	// source clocks as one-cycle ticks off rising chain bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dividerOutputPulse <= 1'b0;
			timeBaseTick <= 1'b0;
			watchdogTick <= 1'b0;
			timerSrcTick <= 3'h0;
			warmupTick <= 1'b0;
		end else begin
			dividerOutputPulse <= timeBaseCtl[`CTSC_TB_DIVIDER_OUTPUT_ENABLE] && periphClkEn &&
				chainRise[`CTSC_DVO_TAP0 +
				int'(timeBaseCtl[`CTSC_TB_DIVIDER_OUTPUT_CLOCK_SELECT_LO+1:`CTSC_TB_DIVIDER_OUTPUT_CLOCK_SELECT_LO])];
			timeBaseTick <= timeBaseCtl[`CTSC_TB_TIME_BASE_ENABLE] && periphClkEn &&
				chainRise[`CTSC_DVO_TAP0 + int'(timeBaseCtl[2:0])];
			watchdogTick <= wdtClkEn && chainRise[`CTSC_WDT_TAP];
			timerSrcTick <= periphClkEn ? {chainRise[`CTSC_TMR_TAP2],
				chainRise[`CTSC_TMR_TAP1], chainRise[`CTSC_TMR_TAP0]} : 3'h0;
			warmupTick <= (mode == ctsc_pkg::MODE_WARM) &&
				chainRise[WARM_UNIT_LOG2 - 1];
		end
	end

	// ====================
	// checks
	property p_reset_normal;
		@(posedge clk) $fell(sys_rst) |-> mode == ctsc_pkg::MODE_NORMAL &&
			cpuClkEn && periphClkEn;
	endproperty
	a_reset_normal: assert property (p_reset_normal)
		else $error("not in normal mode after reset");

	property p_stop_zero;
		@(posedge clk) disable iff (sys_rst)
		mode == ctsc_pkg::MODE_STOP |-> chain == '0 && !oscEnable;
	endproperty
	a_stop_zero: assert property (p_stop_zero)
		else $error("chain or oscillator running in stop");

	property p_idle_gate;
		@(posedge clk) disable iff (sys_rst)
		mode == ctsc_pkg::MODE_IDLE |-> !cpuClkEn && !wdtClkEn &&
			periphClkEn && !watchdogTick;
	endproperty
	a_idle_gate: assert property (p_idle_gate)
		else $error("idle clock gating wrong");

	property p_idle_wake;
		@(posedge clk) disable iff (sys_rst)
		(mode == ctsc_pkg::MODE_IDLE && irqRequest) |=>
			mode == ctsc_pkg::MODE_NORMAL &&
			idleResumeService == $past(interruptMasterEnableFlag) &&
			!sysCtlSecond[`CTSC_S2_IDLE];
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("idle exit wrong");

	property p_level_skip;
		@(posedge clk) disable iff (sys_rst)
		(mode == ctsc_pkg::MODE_NORMAL && stopWrite &&
			pwdata[`CTSC_S1_STOP_RELEASE_METHOD] && pinSync) |=>
			mode == ctsc_pkg::MODE_WARM ##1 chain == CHAIN_W'(1);
	endproperty
	a_level_skip: assert property (p_level_skip)
		else $error("level stop with pin high did not skip to warm-up");

	property p_release_clear;
		@(posedge clk) disable iff (sys_rst)
		stopRelease |=> !sysCtlFirst[`CTSC_S1_STOP] &&
			mode == ctsc_pkg::MODE_WARM && chain == '0;
	endproperty
	a_release_clear: assert property (p_release_clear)
		else $error("stop release did not clear stop bit");

	property p_warm_gate;
		@(posedge clk) disable iff (sys_rst)
		mode == ctsc_pkg::MODE_WARM |-> !cpuClkEn && !periphClkEn &&
			oscEnable == sysCtlSecond[`CTSC_S2_XEN];
	endproperty
	a_warm_gate: assert property (p_warm_gate)
		else $error("clocks open during warm-up");

	property p_warm_end;
		@(posedge clk) disable iff (sys_rst)
		warmDone |=> mode == ctsc_pkg::MODE_NORMAL && resumeNext;
	endproperty
	a_warm_end: assert property (p_warm_end)
		else $error("warm-up end did not resume");

	property p_bit4_zero;
		@(posedge clk) disable iff (sys_rst)
		$rose(wrEn) |=> !timeBaseCtl[`CTSC_TB_ZERO];
	endproperty
	a_bit4_zero: assert property (p_bit4_zero)
		else $error("time base bit 4 set");

	c_idle: cover property (@(posedge clk) disable iff (sys_rst)
		mode == ctsc_pkg::MODE_IDLE ##1 mode == ctsc_pkg::MODE_NORMAL);
	c_stop: cover property (@(posedge clk) disable iff (sys_rst)
		mode == ctsc_pkg::MODE_STOP ##1 mode == ctsc_pkg::MODE_WARM);
	c_warm: cover property (@(posedge clk) disable iff (sys_rst) warmDone);
endmodule

// file: sim/ctsc_core_model.sv
// stand-in for the core and peripherals fed by the clock controller
// assumes the controller's clock enables and machine state on clk
module ctsc_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// from the controller
	input wire logic cpuClkEn,
	input wire logic periphClkEn,
	input wire ctsc_pkg::ctsc_mstate_e machState,
	input wire logic instrDone,
	// from the bench
	input wire logic [3:0] lenReq,
	input wire logic [3:0] irqDelay,
	input wire logic irqFire,
	// to the controller
	output logic instrStart,
	output logic [3:0] instrLen,
	output logic irqRequest,
	// to the bench
	output logic busy,
	output logic [7:0] lastCycles
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cycCount;
	logic [3:0] irqWait;
	logic irqPend;

	// ====================
	// instruction issue
	// issued only at S3 so every instruction starts on a cycle boundary
	always @(posedge clk) begin
		instrStart <= 1'b0;
		if (sys_rst) begin
			instrLen <= 4'h1;
			busy <= 1'b0;
			cycCount <= 8'h00;
			lastCycles <= 8'h00;
		end else if (busy) begin
			cycCount <= cycCount + 8'h01;
			if (instrDone) begin
				busy <= 1'b0;
				lastCycles <= cycCount;
			end
		end else if (cpuClkEn && lenReq != 4'h0 &&
				machState == ctsc_pkg::MST_S3) begin
			instrStart <= 1'b1;
			instrLen <= lenReq;
			busy <= 1'b1;
			cycCount <= 8'h00;
		end
	end

	// ====================
	// peripheral interrupt, prompt or late, held until the core runs
	always @(posedge clk) begin
		if (sys_rst) begin
			irqPend <= 1'b0;
			irqWait <= 4'h0;
			irqRequest <= 1'b0;
		end else if (irqFire) begin
			irqPend <= 1'b1;
			irqWait <= irqDelay;
		end else if (irqPend && periphClkEn) begin
			if (irqWait == 4'h0) begin
				irqRequest <= 1'b1;
				irqPend <= 1'b0;
			end else begin
				irqWait <= irqWait - 4'h1;
			end
		end else if (cpuClkEn) begin
			irqRequest <= 1'b0;
		end
	end
endmodule

// file: sim/ctsc_clock_ctrl_test.sv
// self-checking bench for the clock, timing and standby controller
// assumes ctsc_cfg.svh on the include path and the core model beside it
`include "ctsc_cfg.svh"
module ctsc_clock_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WARM_LOG2 = 4;
	localparam logic [11:0] A_DCC = {2'b00, `CTSC_IDX_DCC, 2'b00};
	localparam logic [11:0] A_TB = {2'b00, `CTSC_IDX_TBDC, 2'b00};
	localparam logic [11:0] A_S1 = {2'b00, `CTSC_IDX_SYS1, 2'b00};
	localparam logic [11:0] A_S2 = {2'b00, `CTSC_IDX_SYS2, 2'b00};
	localparam logic [11:0] A_ST = {2'b00, `CTSC_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_BAD = 12'h0EC;
	logic clk, sysRst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic stopPin, irqRequest, interrupt_master_enable_flag, instrStart, instrDone;
	logic [3:0] instrLen, lenReq, irqDelay;
	logic oscEnable, cpuClkEn, wdtClkEn, periphClkEn, xenResetReq;
	logic dividerOutputPulse, timeBaseTick, watchdogTick, warmupTick;
	logic [2:0] timerSrcTick;
	logic idleResumeService, resumeNext, irqFire, busy;
	logic [7:0] lastCycles, c1, c15;
	ctsc_pkg::ctsc_mstate_e machState, s;
	int nFail = 0, cmpCount = 0, cycles = 0, ticks, n0, n1, n2;
	int tDvo, tTb, tMid, tHigh;

	ctsc_clock_ctrl #(.WARM_UNIT_LOG2(WARM_LOG2)) DUT (.clk(clk),
		.sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stopPin(stopPin), .irqRequest(irqRequest),
		.interruptMasterEnableFlag(interrupt_master_enable_flag), .instrStart(instrStart),
		.instrLen(instrLen), .oscEnable(oscEnable), .cpuClkEn(cpuClkEn),
		.wdtClkEn(wdtClkEn), .periphClkEn(periphClkEn),
		.xenResetReq(xenResetReq), .machState(machState),
		.instrDone(instrDone), .dividerOutputPulse(dividerOutputPulse),
		.timeBaseTick(timeBaseTick), .watchdogTick(watchdogTick),
		.timerSrcTick(timerSrcTick), .warmupTick(warmupTick),
		.idleResumeService(idleResumeService), .resumeNext(resumeNext));
	ctsc_core_model core (.clk(clk), .sys_rst(sysRst), .cpuClkEn(cpuClkEn),
		.periphClkEn(periphClkEn), .machState(machState),
		.instrDone(instrDone), .lenReq(lenReq), .irqDelay(irqDelay),
		.irqFire(irqFire), .instrStart(instrStart), .instrLen(instrLen),
		.irqRequest(irqRequest), .busy(busy), .lastCycles(lastCycles));

	// ====================
	// clock, timeout, report
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nFail++;
			endSim();
		end
	end
	task automatic endSim();
		if (nFail == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ====================
	// apb master: setup, access held until pready at an edge
	task automatic xfer(input logic wr, input logic [11:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, {24'h000000, d}, q, e);
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] m,
			input logic [31:0] x, input logic ex);
		logic [31:0] q;
		logic e;
		xfer(1'b0, a, 32'h00000000, q, e);
		chk(q & m, x);
		chk(32'(e), 32'(ex));
	endtask
	task automatic runInstr(input logic [3:0] n, output logic [7:0] c);
		@(posedge clk);
		lenReq <= n;
		@(posedge clk);
		while (busy !== 1'b1) @(posedge clk);
		lenReq <= 4'h0;
		while (busy !== 1'b0) @(posedge clk);
		c = lastCycles;
	endtask
	// warm-up length in clocks; only differences are compared
	task automatic stopRun(input logic [7:0] v, input int wt, output int n);
		int w;
		wr(A_S1, v);
		repeat (2) @(negedge clk);
		chk(32'({oscEnable, periphClkEn, cpuClkEn}), 32'h0);
		repeat (8) @(negedge clk);
		chk(32'(oscEnable), 32'h0);
		@(posedge clk);
		stopPin <= 1'b1;
		n = 0;
		w = 0;
		while (oscEnable !== 1'b1) @(posedge clk);
		chk(32'(periphClkEn), 32'h0);
		while (cpuClkEn !== 1'b1) begin
			@(posedge clk);
			n++;
			w += int'(warmupTick === 1'b1);
		end
		chk(32'(w), 32'(wt));
		rdChk(A_S1, 32'h80, 32'h0, 1'b0);
		stopPin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// ====================
	// test sequence
	initial begin
		clk = 1'b0;
		sysRst = 1'b1;
		{psel, penable, pwrite, stopPin, interrupt_master_enable_flag, irqFire} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		lenReq = 4'h0;
		irqDelay = 4'h0;
		repeat (5) @(posedge clk);
		sysRst <= 1'b0;
		@(negedge clk);
		chk(32'({oscEnable, cpuClkEn, wdtClkEn, periphClkEn, xenResetReq}),
			32'h1E);
		rdChk(A_TB, 32'hFF, 32'h00, 1'b0);
		rdChk(A_S1, 32'hFC, 32'h00, 1'b0);
		rdChk(A_S2, 32'hF0, 32'h80, 1'b0);
		rdChk(A_DCC, 32'h20, 32'h00, 1'b0);
		rdChk(A_ST, 32'h0F, 32'h01, 1'b0);
		wr(A_TB, 8'hEF);
		rdChk(A_TB, 32'hFF, 32'hEF, 1'b0);
		wr(A_TB, 8'h00);
		wr(A_DCC, 8'h20);
		rdChk(A_DCC, 32'h20, 32'h20, 1'b0);
		wr(A_DCC, 8'h00);
		rdChk(A_BAD, 32'hFFFFFFFF, 32'h0, 1'b1);
		ticks = 0;
		repeat (64) begin
			@(posedge clk);
			if (timerSrcTick[0] === 1'b1)
				ticks++;
		end
		chk(32'(ticks), 32'h8);
		// one full period of the slowest tap used here
		wr(A_TB, 8'h88);
		tDvo = 0;
		tTb = 0;
		tMid = 0;
		tHigh = 0;
		repeat (1 << (`CTSC_DVO_TAP0 + 1)) begin
			@(posedge clk);
			tDvo += int'(dividerOutputPulse === 1'b1);
			tTb += int'(timeBaseTick === 1'b1);
			tMid += int'(timerSrcTick[1] === 1'b1);
			tHigh += int'(timerSrcTick[2] === 1'b1);
		end
		chk(32'(tDvo), 32'h1);
		chk(32'(tTb), 32'h1);
		chk(32'(tMid), 32'h40);
		chk(32'(tHigh), 32'h4);
		wr(A_TB, 8'h00);
		repeat (8) begin
			@(negedge clk);
			s = machState;
			@(negedge clk);
			chk(32'(machState), 32'({s[2:0], s[3]}));
		end
		runInstr(4'h1, c1);
		runInstr(4'hF, c15);
		chk(32'(c15 - c1), 32'h38);
		// late wake-up with master enable, then prompt wake-up without it
		for (int k = 1; k >= 0; k--) begin
			interrupt_master_enable_flag <= k[0];
			wr(A_S2, 8'h90);
			repeat (2) @(negedge clk);
			chk(32'({cpuClkEn, wdtClkEn, periphClkEn}), 32'h1);
			s = machState;
			@(posedge clk);
			irqDelay <= 4'(k * 6);
			irqFire <= 1'b1;
			@(posedge clk);
			irqFire <= 1'b0;
			chk(32'(machState), 32'(s));
			while (idleResumeService !== 1'b1 && resumeNext !== 1'b1)
				@(posedge clk);
			chk(32'({idleResumeService, resumeNext}),
				k == 1 ? 32'h2 : 32'h1);
			rdChk(A_ST, 32'h0F, 32'h01, 1'b0);
		end
		stopRun(8'h80, 3, n0);
		stopRun(8'h84, 1, n1);
		wr(A_DCC, 8'h20);
		stopRun(8'h88, 2, n2);
		chk(32'(n0 - n1), 32'(2 << WARM_LOG2));
		chk(32'(n2 - n1), 32'(1 << WARM_LOG2));
		@(posedge clk);
		stopPin <= 1'b1;
		repeat (4) @(posedge clk);
		wr(A_S1, 8'hC0);
		repeat (2) @(negedge clk);
		chk(32'(oscEnable), 32'h1);
		rdChk(A_ST, 32'h0F, 32'h08, 1'b0);
		while (cpuClkEn !== 1'b1) @(posedge clk);
		stopPin <= 1'b0;
		endSim();
	end
endmodule
